/* File: hdl/iwd_prescaler.sv */
// Seconds prescaler that pulses once per timeout count period
module iwd_prescaler
  import iwd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = IWD_TICK_CYCLES
)(
  input  wire logic clk_sys,   // System clock
  input  wire logic rst_b,     // Async reset, active low
  input  wire logic restart,   // Restart the period, count loads one
  input  wire logic run,       // Count only while running
  output logic      tick       // One-cycle pulse each period
);

  initial
  begin
    if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } iwd_psc_s;

  iwd_psc_s q;
  iwd_psc_s next_q;

  // ==========================================================================
  // Next state: restart wins so a kick always gives a full second
  // Restart starts at one: the registered tick costs the period a cycle
  always_comb
  begin
    next_q      = q;
    next_q.tick = 1'b0;
    if (restart)
      next_q.cnt = 32'h0000_0001;
    else if (!run)
      next_q.cnt = 32'h0000_0000;
    else if (q.cnt == TICK_CYCLES - 1)
    begin
      next_q.cnt  = 32'h0000_0000;
      next_q.tick = 1'b1;
    end
    else
      next_q.cnt = q.cnt + 32'h0000_0001;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= next_q;
  end

  assign tick = q.tick;

endmodule : iwd_prescaler

/* File: hdl/iwd_top.sv */
// Top of the I/O port watchdog timer: port decode, countdown, expiry
module iwd_top
  import iwd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = IWD_TICK_CYCLES
)(
  input  wire logic        clk_sys,     // System clock, 40 MHz
  input  wire logic        rst_b,       // Async reset, active low
  input  wire logic [15:0] io_addr,     // I/O port address
  input  wire logic        io_wr,       // Byte write strobe, one cycle
  input  wire logic        io_rd,       // Byte read strobe, one cycle
  input  wire logic [7:0]  io_wdata,    // Write data byte
  output logic      [7:0]  io_rdata,    // Read data, valid cycle after io_rd
  output logic             wdt_enabled, // Watchdog is counting
  output logic      [7:0]  wdt_remain,  // Seconds left in countdown
  output logic             wdt_timeout  // System reset request
);

  initial
  begin
    if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    iwd_state_e            state;
    logic [IWD_CNT_W-1:0]  remain;
    logic                  timeout;
    logic [7:0]            rdata;
  } iwd_top_s;

  iwd_top_s q;
  iwd_top_s next_q;
  logic     tick;
  logic     load_hit;
  logic     dis_hit;

  // ==========================================================================
  // Port decode; any byte is taken, 00 is host misuse and loads as 1 s
  assign load_hit = io_wr && (io_addr == IWD_ADDR_LOAD);
  assign dis_hit  = io_rd && (io_addr == IWD_ADDR_DISABLE);

  // ==========================================================================
  // Seconds prescaler, restarted on each load so the first second is whole
  iwd_prescaler #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_psc (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .restart (load_hit),
    .run     (q.state == IWD_RUN),
    .tick    (tick)
  );

  // ==========================================================================
  // Countdown state; disable read wins over a load in the same cycle
  always_comb
  begin
    next_q       = q;
    next_q.rdata = IWD_RDATA_IDLE;
    if (dis_hit)
    begin
      next_q.state   = IWD_OFF;
      next_q.timeout = 1'b0;
    end
    else if (load_hit)
    begin
      next_q.state   = IWD_RUN;
      next_q.remain  = (io_wdata < IWD_CNT_MIN) ? IWD_CNT_MIN : io_wdata;
      next_q.timeout = 1'b0;
    end
    else
    begin
      unique case (q.state)
        IWD_OFF: next_q.remain = q.remain;
        IWD_RUN:
        begin
          if (tick)
          begin
            if (q.remain == IWD_CNT_MIN)
            begin
              // Expiry: sticky request, countdown parks at zero
              next_q.remain  = IWD_CNT_RST;
              next_q.state   = IWD_OFF;
              next_q.timeout = 1'b1;
            end
            else
              next_q.remain = q.remain - 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q.state   <= IWD_OFF;
      q.remain  <= IWD_CNT_RST;
      q.timeout <= 1'b0;
      q.rdata   <= IWD_RDATA_IDLE;
    end
    else
      q <= next_q;
  end

  // ==========================================================================
  // Outputs straight from the state register
  assign io_rdata    = q.rdata;
  assign wdt_enabled = (q.state == IWD_RUN);
  assign wdt_remain  = q.remain;
  assign wdt_timeout = q.timeout;

endmodule : iwd_top

/* File: shared/iwd_pkg.sv */
// Package of constants and types for the I/O port watchdog timer
package iwd_pkg;

  // ==========================================================================
  // Port map
  localparam logic [15:0] IWD_ADDR_LOAD    = 16'h0443;
  localparam logic [15:0] IWD_ADDR_DISABLE = 16'h0444;

  // ==========================================================================
  // Field layout and reset values
  localparam int          IWD_CNT_W      = 8;
  localparam logic [7:0]  IWD_CNT_MIN    = 8'h01;
  localparam logic [7:0]  IWD_CNT_RST    = 8'h00;
  localparam logic [7:0]  IWD_RDATA_IDLE = 8'h00;

  // ==========================================================================
  // Timing
  localparam int          IWD_CLK_HZ        = 40_000_000;
  localparam int          IWD_TICK_S        = 1;
  localparam int          IWD_TICK_CYCLES   = IWD_CLK_HZ * IWD_TICK_S;

  typedef enum logic [0:0] {IWD_OFF, IWD_RUN} iwd_state_e;

endpackage : iwd_pkg

/* File: verif/iwd_properties.sv */
// Port checker for the watchdog timer
module iwd_properties
  import iwd_pkg::*;
#(parameter int unsigned TICK_CYCLES = IWD_TICK_CYCLES)(
  input wire logic        clk_sys,     // Clock
  input wire logic        rst_b,       // Reset
  input wire logic [15:0] io_addr,     // Port
  input wire logic        io_wr,       // Write
  input wire logic        io_rd,       // Read
  input wire logic        wdt_enabled, // Running
  input wire logic [7:0]  wdt_remain,  // Left
  input wire logic        wdt_timeout  // Fired
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Disable request, also excuses a falling enable
  wire dis = io_rd && io_addr == IWD_ADDR_DISABLE;
  load_start_a: assert property (io_wr && io_addr == IWD_ADDR_LOAD
    |=> wdt_enabled && !wdt_timeout) else $error("load");
  read_stop_a: assert property (dis |=> !wdt_enabled && !wdt_timeout)
    else $error("read");
  tick_hold_a: assert property ($changed(wdt_remain) && wdt_enabled
    ##0 (!io_wr && !io_rd) [*8] |-> $stable(wdt_remain)) else $error("tick");
  expire_flag_a: assert property ($fell(wdt_enabled) && !$past(dis)
    |-> wdt_timeout && wdt_remain == 8'h00) else $error("expiry");
  timeout_hold_a: assert property (wdt_timeout && !dis
    && !(io_wr && io_addr == IWD_ADDR_LOAD) |=> wdt_timeout) else $error("timeout hold");
  off_freeze_a: assert property (!wdt_enabled
    && !(io_wr && io_addr == IWD_ADDR_LOAD) |=> $stable(wdt_remain)) else $error("frozen");
endmodule : iwd_properties
bind iwd_top iwd_properties #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

/* File: verif/testbench.sv */
// Watchdog timer bench
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import iwd_pkg::*;
  logic clk_sys = '0, rst_b = '0, io_wr = '0, io_rd = '0, wdt_enabled, wdt_timeout;
  logic [15:0] io_addr = '0;
  logic [7:0] io_wdata = '0, io_rdata, wdt_remain, v;
  logic [9:0] last = '0;
  logic [41:0] e, q[$];
  int cyc = 0, bad_count = 0, num_checks = 0, seed = 70;
  iwd_top #(.TICK_CYCLES(10)) dut (.*);
  always #12.5 clk_sys = ~clk_sys;
  // Match each output change, with its cycle, to the oldest note
  always @(negedge clk_sys)
  begin
    cyc++;
    if ({wdt_enabled, wdt_timeout, wdt_remain} !== last)
    begin
      last = {wdt_enabled, wdt_timeout, wdt_remain};
      e = q.size() ? q.pop_front() : '0;
      num_checks++;
      if (e !== {cyc, last})
        $display("[ERR] state exp %h got %h", e, {cyc, last});
      bad_count += int'(e !== {cyc, last});
    end
    // Read data must always come back idle
    num_checks++;
    if (io_rdata !== IWD_RDATA_IDLE)
    begin
      $display("[ERR] io_rdata exp %h got %h", IWD_RDATA_IDLE, io_rdata);
      bad_count++;
    end
  end
  task automatic put(logic [15:0] a, logic w, logic [7:0] d);
    @(posedge clk_sys);
    #2 {io_addr, io_wr, io_rd, io_wdata} = {a, w, !w, d};
    @(posedge clk_sys);
    #2 {io_wr, io_rd} = '0;
  endtask : put
  task automatic ld(logic [7:0] d, int k);
    put(IWD_ADDR_LOAD, '1, d);
    for (int i = 0; i <= k; i++)
      q.push_back({cyc + 1 + i * 10, d > i, d == i, 8'(d - i)});
    repeat (k * 10 + 3) @(negedge clk_sys);
  endtask : ld
  task automatic rd(logic [7:0] r);
    put(IWD_ADDR_DISABLE, '0, '0);
    q.push_back({cyc + 1, 2'h0, r});
    repeat (30) @(negedge clk_sys);
  endtask : rd
  // Expire, refresh early, then disable mid-count
  initial
  begin
    v = 8'($random(seed)) | 8'h01;
    repeat (10) @(posedge clk_sys);
    #2 rst_b = '1;
    ld(v, v);
    ld(8'h05, 1);
    ld(8'h05, 2);
    rd(8'h03);
    results(0);
  end
  // Hang guard
  initial #200000 results(1);
  task automatic results(int miss);
    bad_count += miss;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
endmodule : testbench
